// ==== common/bcs_pkg.sv ====
package bcs_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TIMER = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  // Control register fields
  localparam int CTRL_CHG_EN = 0;
  localparam int CTRL_TERM_EN = 1;
  localparam int CTRL_LINEAR_PASS_DISABLE = 2;
  localparam int CTRL_MASK = 3;
  localparam int CTRL_TMR2X = 4;
  localparam int CTRL_RESTORE = 5;
  localparam int CTRL_RECHG_LSB = 8;
  localparam int CTRL_TOPOFF_LSB = 12;
  localparam logic [31:0] CTRL_RST = 32'h0000_0113;
  // Timer register fields
  localparam int TMR_TRI_EN = 0;
  localparam int TMR_PRE_EN = 1;
  localparam int TMR_FAST_EN = 2;
  localparam int TMR_FAST_LSB = 4;
  localparam logic [31:0] TMR_RST = 32'h0000_0007;
  // Status register fields
  localparam int STS_PHASE_LSB = 0;
  localparam int STS_TRI_EXP = 4;
  localparam int STS_PRE_EXP = 5;
  localparam int STS_FAST_EXP = 6;
  localparam int STS_SWITCH = 7;
  localparam int STS_SYSREG = 8;
  localparam int STS_ENABLED = 9;
  // Default recharge offset code for 200 mV
  localparam logic [3:0] RECHG_DEFAULT = 4'h1;
  // Timing: clock rate and tick base
  localparam int CLK_HZ = 25_000_000;
  localparam int TICK_S = 1;
  localparam int TICK_CYC = CLK_HZ * TICK_S;
  localparam int TRI_H = 1;
  localparam int PRE_H = 2;
  localparam int FAST_H = 12;
  localparam int SEC_PER_H = 3600;
  localparam int TOPOFF_UNIT_S = 900;
  localparam int PULSE_CYC = 4;
  // Phase codes
  localparam logic [2:0] PH_IDLE = 3'h0;
  localparam logic [2:0] PH_TRI = 3'h1;
  localparam logic [2:0] PH_PRE = 3'h2;
  localparam logic [2:0] PH_FAST = 3'h3;
  localparam logic [2:0] PH_CV = 3'h4;
  localparam logic [2:0] PH_TOP = 3'h6;
  localparam logic [2:0] PH_TERM = 3'h7;
  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_TRI = 7'b0000010,
    ST_PRE = 7'b0000100,
    ST_FAST = 7'b0001000,
    ST_CV = 7'b0010000,
    ST_TOP = 7'b0100000,
    ST_TERM = 7'b1000000
  } bcs_state_e;
endpackage

// ==== common/bcs_tick_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface bcs_tick_if;
  logic pause;
  logic half;
  logic tick;
  modport src (input pause, input half, output tick);
  modport dst (output pause, output half, input tick);
endinterface
`default_nettype wire

// ==== core/bcs_seq.sv ====
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// (RULE_01) Charging enabled only when enable bit is 1 and enable pin is low
// (RULE_02) Start needs switching, no faults, enabled, battery below target voltage
// (RULE_03) Terminate in CV when current below threshold, unless regulating
// (RULE_04) After completion, toggling pin or bit starts a new cycle
// (RULE_05) Auto restart when battery falls below selectable recharge threshold
// (RULE_06) After termination open battery switch unless supplement needed, keep rail
// (RULE_07) Phase reported as three-bit code
// (RULE_08) Notify pulse on phase change and completion, phase pulses maskable
// (RULE_09) At start choose trickle, pre-charge or fast from battery voltage
// (RULE_10) In regulation suppress termination, reduce current, half-rate timer
// (RULE_11) Fixed trickle threshold; pre-charge skipped if fast threshold is lower
// (RULE_12) Linear pass disable stops min-plus rail regulation above short threshold
// (RULE_13) No termination while disabled; deferred while regulating
// (RULE_14) Optional top-off delay with code 110, latched, then 111, notify
// (RULE_15) Top-off timer pauses and slows with the safety timer
// (RULE_16) Top-off timer reset by pin enable, termination rise, restore bit
// (RULE_17) Safety timeout stops charging, sets flag, pulses notify
// (RULE_18) Per-phase timer enables; enabling mid-phase restarts count
// (RULE_19) Half rate in regulation only if doubling bit set when it began; code also halves when the bit is set later in regulation
// (RULE_20) Timer paused during faults; cycle restart resets it
// (RULE_21) Fast timer reset on restart, phase change, duration write, re-enable
// (RULE_22) Default timers: trickle 1h, pre-charge 2h, fast 12h
// (RULE_23) Timer ticks from prescaled clock with divide-by-two option
module bcs_seq
  import bcs_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYC,
  parameter int TICKS_PER_H = SEC_PER_H / TICK_S,
  parameter int TOPOFF_TICKS = TOPOFF_UNIT_S / TICK_S
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic charge_enable_pin_n,
  input wire logic conv_ready,
  input wire logic temp_fault,
  input wire logic vbat_below_target,
  input wire logic vbat_below_recharge,
  input wire logic vbat_below_deep,
  input wire logic vbat_below_fast_entry,
  input wire logic vbat_below_sysmin,
  input wire logic cv_loop_active,
  input wire logic ichg_below_term,
  input wire logic input_current_limit_active,
  input wire logic input_voltage_limit_active,
  input wire logic thermal_reg_active,
  input wire logic supplement_needed,
  output logic battery_switch,
  output logic charge_on,
  output logic current_reduced,
  output logic sys_track_batt,
  output logic sysmin_reg_on,
  output logic [3:0] recharge_threshold_sel,
  output logic [2:0] charge_phase_code,
  output logic host_event_pulse_n
);
  // Pin synchroniser: three stages, change accepted when last two agree
  logic [2:0] pin_sync_r;
  logic pin_n_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_sync_r <= 3'b111;
      pin_n_r <= 1'b1;
    end
    else
    begin
      pin_sync_r <= {pin_sync_r[1:0], charge_enable_pin_n};
      if (pin_sync_r[2] == pin_sync_r[1])
        pin_n_r <= pin_sync_r[2];
    end
  end
  // Registers and write side effects
  logic [31:0] ctrl_r, ctrl_nxt, tmr_r, tmr_nxt;
  logic wr, rd_ok, dur_wr, restore;
  assign wr = psel && penable && pwrite;
  assign dur_wr = wr && paddr == OFF_TIMER
    && pwdata[TMR_FAST_LSB +: 2] != tmr_r[TMR_FAST_LSB +: 2]; // RULE_21
  assign restore = wr && paddr == OFF_CTRL && pwdata[CTRL_RESTORE];
  assign rd_ok = paddr == OFF_CTRL || paddr == OFF_TIMER || paddr == OFF_STATUS;
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    tmr_nxt = tmr_r;
    if (restore)
    begin
      ctrl_nxt = CTRL_RST;
      tmr_nxt = TMR_RST;
    end
    else if (wr && paddr == OFF_CTRL)
      ctrl_nxt = {16'h0, pwdata[15:6], 1'b0, pwdata[4:0]};
    else if (wr && paddr == OFF_TIMER)
      tmr_nxt = {26'h0, pwdata[5:4], 1'b0, pwdata[2:0]};
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= CTRL_RST;
      tmr_r <= TMR_RST;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      tmr_r <= tmr_nxt;
    end
  end
  logic enabled, reg_active;
  assign enabled = ctrl_r[CTRL_CHG_EN] && !pin_n_r; // RULE_01
  assign reg_active = input_current_limit_active || input_voltage_limit_active
    || thermal_reg_active;
  // Enable edge detection for restart and timer resets
  logic en_d_r, pin_d_r, tri_en_d_r, pre_en_d_r, fast_en_d_r, slow_r, slow_nxt;
  logic en_rise, pin_rise, tri_en_rise, pre_en_rise, fast_en_rise;
  assign en_rise = enabled && !en_d_r;
  assign pin_rise = !pin_n_r && pin_d_r;
  assign tri_en_rise = tmr_r[TMR_TRI_EN] && !tri_en_d_r;
  assign pre_en_rise = tmr_r[TMR_PRE_EN] && !pre_en_d_r;
  assign fast_en_rise = tmr_r[TMR_FAST_EN] && !fast_en_d_r;
  // Doubling is caught whenever the bit is set during regulation; later clears are ignored
  always_comb
  begin
    slow_nxt = slow_r;
    if (!reg_active)
      slow_nxt = 1'b0;
    else if (ctrl_r[CTRL_TMR2X])
      slow_nxt = 1'b1; // RULE_19
  end
  // Phase machine
  bcs_state_e st_r, st_nxt;
  logic [2:0] tri_exp_r, tri_exp_nxt;
  logic [31:0] sft_r, sft_nxt, top_r, top_nxt, top_lim_r, top_lim_nxt;
  logic start_ok, timeout, fault, term_det, ev_phase, ev_done;
  logic [2:0] code_nxt;
  bcs_tick_if tk ();
  assign fault = temp_fault || !conv_ready;
  assign tk.pause = fault; // RULE_20 RULE_15
  assign tk.half = slow_r; // RULE_10 RULE_15
  bcs_tick #(.DIV(TICK_DIV)) u_tick (.pclk(pclk), .presetn(presetn), .tk(tk));
  assign start_ok = conv_ready && !temp_fault && tri_exp_r == 3'h0 && enabled
    && vbat_below_target; // RULE_02
  assign term_det = cv_loop_active && ichg_below_term && !reg_active
    && ctrl_r[CTRL_TERM_EN]; // RULE_03 RULE_10 RULE_13
  // Phase selection from battery voltage at entry
  function automatic bcs_state_e pick(input logic deep, input logic low);
    if (deep)
      pick = ST_TRI;
    else if (low)
      pick = ST_PRE;
    else
      pick = ST_FAST;
  endfunction
  // Hours to ticks for the active safety limit
  function automatic logic [31:0] hours(input int h);
    hours = 32'(h * TICKS_PER_H);
  endfunction
  logic [31:0] sft_lim;
  logic sft_en;
  always_comb
  begin
    sft_lim = hours(FAST_H);
    sft_en = 1'b0;
    case (st_r)
      ST_TRI:
      begin
        sft_lim = hours(TRI_H); // RULE_22
        sft_en = tmr_r[TMR_TRI_EN];
      end
      ST_PRE:
      begin
        sft_lim = hours(PRE_H); // RULE_22
        sft_en = tmr_r[TMR_PRE_EN];
      end
      ST_FAST, ST_CV, ST_TOP:
      begin
        sft_lim = hours(FAST_H) >> tmr_r[TMR_FAST_LSB +: 2]; // RULE_22
        sft_en = tmr_r[TMR_FAST_EN]; // RULE_18
      end
      default:
      begin
        sft_lim = hours(FAST_H);
        sft_en = 1'b0;
      end
    endcase
  end
  assign timeout = sft_en && sft_r >= sft_lim;
  always_comb
  begin
    st_nxt = st_r;
    sft_nxt = sft_r;
    top_nxt = top_r;
    top_lim_nxt = top_lim_r;
    tri_exp_nxt = tri_exp_r;
    ev_done = 1'b0;
    if (sft_en && tk.tick)
      sft_nxt = sft_r + 32'h1;
    if ((st_r == ST_TRI && tri_en_rise) || (st_r == ST_PRE && pre_en_rise)
      || ((st_r == ST_FAST || st_r == ST_CV) && (fast_en_rise || dur_wr)))
      sft_nxt = 32'h0; // RULE_18 RULE_21
    case (st_r)
      ST_IDLE, ST_TERM:
      begin
        if (start_ok && (st_r == ST_IDLE || en_rise || vbat_below_recharge)) // RULE_04 RULE_05
        begin
          st_nxt = pick(vbat_below_deep, vbat_below_fast_entry); // RULE_09 RULE_11
          sft_nxt = 32'h0; // RULE_20 RULE_21
        end
      end
      ST_TRI:
        if (!vbat_below_deep)
        begin
          st_nxt = vbat_below_fast_entry ? ST_PRE : ST_FAST; // RULE_11
          sft_nxt = 32'h0;
        end
      ST_PRE:
        if (!vbat_below_fast_entry)
        begin
          st_nxt = ST_FAST;
          sft_nxt = 32'h0; // RULE_21
        end
      ST_FAST:
        if (cv_loop_active)
          st_nxt = ST_CV;
      ST_CV:
        if (term_det)
        begin
          top_lim_nxt = 32'(ctrl_r[CTRL_TOPOFF_LSB +: 2]) * 32'(TOPOFF_TICKS); // RULE_14
          top_nxt = 32'h0;
          st_nxt = ctrl_r[CTRL_TOPOFF_LSB +: 2] != 2'h0 ? ST_TOP : ST_TERM;
          ev_done = ctrl_r[CTRL_TOPOFF_LSB +: 2] == 2'h0;
        end
      ST_TOP:
      begin
        if (tk.tick)
          top_nxt = top_r + 32'h1; // RULE_15
        if (top_r >= top_lim_r)
        begin
          st_nxt = ST_TERM; // RULE_14
          ev_done = 1'b1;
        end
      end
      default:
        st_nxt = ST_IDLE;
    endcase
    if (pin_rise || restore)
      top_nxt = 32'h0; // RULE_16
    // Re-enable clears expiry first so a same-cycle expiry still sets it
    if (en_rise)
      tri_exp_nxt = 3'h0;
    if (timeout)
    begin
      st_nxt = ST_IDLE; // RULE_17
      tri_exp_nxt = tri_exp_r | {st_r == ST_FAST || st_r == ST_CV || st_r == ST_TOP,
        st_r == ST_PRE, st_r == ST_TRI};
      ev_done = 1'b1;
    end
    if (!enabled || fault)
      st_nxt = ST_IDLE;
  end
  // Phase code lookup
  always_comb
  begin
    case (st_nxt)
      ST_TRI: code_nxt = PH_TRI;
      ST_PRE: code_nxt = PH_PRE;
      ST_FAST: code_nxt = PH_FAST;
      ST_CV: code_nxt = PH_CV;
      ST_TOP: code_nxt = PH_TOP;
      ST_TERM: code_nxt = PH_TERM;
      default: code_nxt = PH_IDLE;
    endcase
  end
  assign ev_phase = code_nxt != charge_phase_code && !ctrl_r[CTRL_MASK]; // RULE_08
  // Notify pulse stretcher
  logic [3:0] pls_r, pls_nxt;
  always_comb
  begin
    pls_nxt = pls_r;
    if (ev_phase || ev_done || timeout)
      pls_nxt = 4'(PULSE_CYC); // RULE_08 RULE_14 RULE_17
    else if (pls_r != 4'h0)
      pls_nxt = pls_r - 4'h1;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= ST_IDLE;
      sft_r <= 32'h0;
      top_r <= 32'h0;
      top_lim_r <= 32'h0;
      tri_exp_r <= 3'h0;
      pls_r <= 4'h0;
      slow_r <= 1'b0;
      en_d_r <= 1'b0;
      pin_d_r <= 1'b1;
      tri_en_d_r <= 1'b1;
      pre_en_d_r <= 1'b1;
      fast_en_d_r <= 1'b1;
      charge_phase_code <= PH_IDLE;
      host_event_pulse_n <= 1'b1;
      battery_switch <= 1'b1;
      charge_on <= 1'b0;
      current_reduced <= 1'b0;
      sys_track_batt <= 1'b0;
      sysmin_reg_on <= 1'b0;
      recharge_threshold_sel <= RECHG_DEFAULT;
    end
    else
    begin
      st_r <= st_nxt;
      sft_r <= sft_nxt;
      top_r <= top_nxt;
      top_lim_r <= top_lim_nxt;
      tri_exp_r <= tri_exp_nxt;
      pls_r <= pls_nxt;
      slow_r <= slow_nxt;
      en_d_r <= enabled;
      pin_d_r <= pin_n_r;
      tri_en_d_r <= tmr_r[TMR_TRI_EN];
      pre_en_d_r <= tmr_r[TMR_PRE_EN];
      fast_en_d_r <= tmr_r[TMR_FAST_EN];
      charge_phase_code <= code_nxt; // RULE_07
      host_event_pulse_n <= pls_nxt == 4'h0;
      battery_switch <= st_nxt != ST_TERM || supplement_needed; // RULE_06
      charge_on <= st_nxt != ST_IDLE && st_nxt != ST_TERM;
      current_reduced <= reg_active; // RULE_10
      sys_track_batt <= st_nxt == ST_TERM; // RULE_06
      sysmin_reg_on <= vbat_below_deep
        || (vbat_below_sysmin && !ctrl_r[CTRL_LINEAR_PASS_DISABLE]); // RULE_12
      recharge_threshold_sel <= ctrl_r[CTRL_RECHG_LSB +: 4]; // RULE_05
    end
  end
  // APB read and answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !rd_ok;
      if (psel && !penable)
        case (paddr)
          OFF_CTRL: prdata <= ctrl_r;
          OFF_TIMER: prdata <= tmr_r;
          OFF_STATUS: prdata <= {22'h0, enabled, sysmin_reg_on, battery_switch,
            tri_exp_r[2], tri_exp_r[1], tri_exp_r[0], 1'b0, charge_phase_code};
          default: prdata <= 32'h0;
        endcase
    end
  end
  // Checks
  property p_term;
    @(posedge pclk) disable iff (!presetn)
    (st_r == ST_CV && !ctrl_r[CTRL_TERM_EN]) |=> st_r != ST_TERM && st_r != ST_TOP;
  endproperty
  a_term: assert property (p_term) else $error("terminated while disabled"); // RULE_13
  property p_enable;
    @(posedge pclk) disable iff (!presetn)
    !enabled |=> st_r == ST_IDLE;
  endproperty
  a_enable: assert property (p_enable) else $error("charging while disabled"); // RULE_01
  property p_code;
    @(posedge pclk) disable iff (!presetn)
    st_r == ST_TERM |-> charge_phase_code == PH_TERM;
  endproperty
  a_code: assert property (p_code) else $error("wrong phase code"); // RULE_07
  property p_timeout;
    @(posedge pclk) disable iff (!presetn)
    timeout |=> st_r == ST_IDLE && tri_exp_r != 3'h0 && !host_event_pulse_n;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not handled"); // RULE_17
  property p_switch;
    @(posedge pclk) disable iff (!presetn)
    (st_r == ST_TERM && !supplement_needed) |-> ##1 (!battery_switch || st_r != ST_TERM);
  endproperty
  a_switch: assert property (p_switch) else $error("switch left closed"); // RULE_06
  property p_regterm;
    @(posedge pclk) disable iff (!presetn)
    (st_r == ST_CV && reg_active) |=> st_r != ST_TOP && st_r != ST_TERM;
  endproperty
  a_regterm: assert property (p_regterm) else $error("terminated in regulation"); // RULE_10
  property p_pulse;
    @(posedge pclk) disable iff (!presetn)
    $fell(host_event_pulse_n) |-> ##1 !host_event_pulse_n[*3];
  endproperty
  a_pulse: assert property (p_pulse) else $error("notify pulse too short"); // RULE_08
  property p_start;
    @(posedge pclk) disable iff (!presetn)
    (st_r == ST_IDLE && !vbat_below_target) |=> st_r == ST_IDLE;
  endproperty
  a_start: assert property (p_start) else $error("start above target"); // RULE_02
endmodule // bcs_seq
`default_nettype wire

// ==== core/bcs_tick.sv ====
`timescale 1ns/1ps
`default_nettype none
module bcs_tick
  import bcs_pkg::*;
#(
  parameter int DIV = TICK_CYC
)(
  input wire logic pclk,
  input wire logic presetn,
  bcs_tick_if.src tk
);
  logic [31:0] cnt_r, cnt_nxt;
  logic half_r, half_nxt;
  logic tick_r, tick_nxt;
  // Prescaler; half rate drops every other base tick
  always_comb
  begin
    cnt_nxt = cnt_r;
    half_nxt = half_r;
    tick_nxt = 1'b0;
    if (!tk.pause)
    begin
      if (cnt_r >= 32'(DIV - 1))
      begin
        cnt_nxt = 32'h0;
        half_nxt = ~half_r;
        tick_nxt = !tk.half || half_r; // RULE_23
      end
      else
        cnt_nxt = cnt_r + 32'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= 32'h0;
      half_r <= 1'b0;
      tick_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      half_r <= half_nxt;
      tick_r <= tick_nxt;
    end
  end
  assign tk.tick = tick_r;
endmodule // bcs_tick
`default_nettype wire

// ==== testbench/battery_charge_sequencer_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module battery_charge_sequencer_bench
  import bcs_pkg::*;
();
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, load_lvl, lfsr_r, lv;
  logic [31:0] pwdata, prdata, rd;
  logic pin_n, conv_ready, temp_fault, icl, ivl, treg, supp, hold, skip, load, err;
  logic vb_tgt, vb_rchg, vb_deep, vb_fast, vb_smin, cv_act, i_term;
  logic sw, chg_on, cur_red, trk, smin_on, pulse_n, pulse_prev;
  logic [3:0] rsel;
  logic [2:0] ph, last_ph;
  logic [2:0] ph_log[$];
  logic [2:0] exp_q[$];
  int bad_count, n_checks, n_pulse, i;

  bcs_seq #(.TICK_DIV(4), .TICKS_PER_H(5), .TOPOFF_TICKS(3)) dut_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .charge_enable_pin_n(pin_n), .conv_ready(conv_ready), .temp_fault(temp_fault),
    .vbat_below_target(vb_tgt), .vbat_below_recharge(vb_rchg), .vbat_below_deep(vb_deep),
    .vbat_below_fast_entry(vb_fast), .vbat_below_sysmin(vb_smin), .cv_loop_active(cv_act),
    .ichg_below_term(i_term), .input_current_limit_active(icl),
    .input_voltage_limit_active(ivl), .thermal_reg_active(treg), .supplement_needed(supp),
    .battery_switch(sw), .charge_on(chg_on), .current_reduced(cur_red),
    .sys_track_batt(trk), .sysmin_reg_on(smin_on), .recharge_threshold_sel(rsel),
    .charge_phase_code(ph), .host_event_pulse_n(pulse_n));
  bcs_batt_model batt_u (.pclk(pclk), .presetn(presetn), .charge_on(chg_on), .hold(hold),
    .skip_pre(skip), .load(load), .load_lvl(load_lvl), .vbat_below_target(vb_tgt),
    .vbat_below_recharge(vb_rchg), .vbat_below_deep(vb_deep), .vbat_below_fast_entry(vb_fast),
    .vbat_below_sysmin(vb_smin), .cv_loop_active(cv_act), .ichg_below_term(i_term));

  // Clock at 25 MHz
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Phase history and notify pulse count
  always @(posedge pclk)
  begin
    if (ph !== last_ph)
      ph_log.push_back(ph);
    if (pulse_prev === 1'b1 && pulse_n === 1'b0)
      n_pulse++;
    last_ph <= ph;
    pulse_prev <= pulse_n;
  end
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // First phase expected from the battery level
  function automatic logic [2:0] exp_start(input logic [7:0] l);
    return (l < 8'h14) ? PH_TRI : ((l < 8'h28) ? PH_PRE : PH_FAST);
  endfunction
  // Full phase order expected for one cycle
  function automatic void build_exp(input logic [7:0] l, input logic sk, input logic top);
    exp_q = {};
    if (l < 8'h14)
      exp_q.push_back(PH_TRI);
    if (l < 8'h28 && !sk)
      exp_q.push_back(PH_PRE);
    if (l < 8'hB4)
      exp_q.push_back(PH_FAST);
    exp_q.push_back(PH_CV);
    if (top)
      exp_q.push_back(PH_TOP);
    exp_q.push_back(PH_TERM);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // One APB transfer; read data and error are taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1);
    chk(n, 1, "pready latency");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_phase(input logic [2:0] p, input int lim);
    int n;
    n = 0;
    while (ph !== p && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
    chk(ph, p, "phase");
  endtask
  // Disable, set the battery level, then enable by the pin
  task automatic start_run(input logic [7:0] l, input logic sk);
    pin_n <= 1'b1;
    wait_cyc(10);
    load_lvl <= l;
    skip <= sk;
    load <= 1'b1;
    @(posedge pclk);
    load <= 1'b0;
    wait_cyc(2);
    ph_log = {};
    n_pulse = 0;
    pin_n <= 1'b0;
  endtask
  task automatic run_full(input logic [7:0] l, input logic sk, input logic top, input int pe);
    int k;
    build_exp(l, sk, top);
    start_run(l, sk);
    wait_phase(PH_TERM, 600);
    wait_cyc(6);
    chk(ph_log.size(), exp_q.size(), "phase count");
    for (k = 0; k < exp_q.size() && k < ph_log.size(); k++)
      chk(ph_log[k], exp_q[k], "phase order");
    chk(n_pulse, (pe < 0) ? exp_q.size() : pe, "pulses");
  endtask
  task automatic tend(input string name);
    $display("test %s done at %0t", name, $time);
  endtask
  // Watchdog
  initial
  begin
    wait_cyc(30000);
    bad_count++;
    print_verdict();
  end
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, load, load_lvl, hold, skip} = '0;
    {temp_fault, icl, ivl, treg, supp, bad_count, n_checks, n_pulse} = '0;
    {presetn, last_ph, pulse_prev, lfsr_r} = {1'b0, 3'h0, 1'b1, 8'h4E};
    pin_n = 1'b1;
    conv_ready = 1'b1;
    wait_cyc(12);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFF_CTRL, 32'h0);
    chk(rd, CTRL_RST, "ctrl reset");
    apb(1'b0, OFF_TIMER, 32'h0);
    chk(rd, TMR_RST, "timer reset");
    apb(1'b0, 8'h0C, 32'h0);
    chk({err, rd}, 33'h1_0000_0000, "unmapped");
    apb(1'b1, OFF_STATUS, 32'hFFFF_FFFF);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rd[2:0], PH_IDLE, "status phase");
    chk({sw, pulse_n, rsel}, {2'b11, RECHG_DEFAULT}, "reset outputs");
    apb(1'b1, OFF_TIMER, 32'h0000_0007);
    tend("reset");
    run_full(8'h0A, 1'b0, 1'b0, -1);
    run_full(8'h1E, 1'b1, 1'b0, -1);
    apb(1'b1, OFF_CTRL, CTRL_RST | 32'h0000_1000);
    run_full(8'h50, 1'b0, 1'b1, -1);
    apb(1'b1, OFF_CTRL, CTRL_RST | 32'h0000_0008);
    run_full(8'h50, 1'b0, 1'b0, 1);
    tend("cycles");
    load_lvl <= 8'h8C;
    load <= 1'b1;
    @(posedge pclk);
    load <= 1'b0;
    wait_phase(PH_FAST, 40);
    wait_phase(PH_TERM, 600);
    load_lvl <= 8'hBE;
    load <= 1'b1;
    @(posedge pclk);
    load <= 1'b0;
    wait_cyc(20);
    chk(ph, PH_TERM, "no restart above recharge");
    apb(1'b1, OFF_CTRL, CTRL_RST & 32'hFFFF_FFFE);
    wait_cyc(2);
    chk({ph, chg_on}, {PH_IDLE, 1'b0}, "bit disable");
    apb(1'b1, OFF_CTRL, CTRL_RST);
    wait_phase(PH_CV, 40);
    tend("restart");
    apb(1'b1, OFF_CTRL, CTRL_RST & 32'hFFFF_FFFD);
    start_run(8'hB4, 1'b0);
    wait_phase(PH_CV, 40);
    wait_cyc(40);
    chk(ph, PH_CV, "term disabled");
    treg <= 1'b1;
    apb(1'b1, OFF_CTRL, CTRL_RST);
    wait_cyc(20);
    chk({ph, cur_red}, {PH_CV, 1'b1}, "term deferred");
    treg <= 1'b0;
    wait_phase(PH_TERM, 20);
    wait_cyc(3);
    chk({sw, trk}, 2'b01, "switch open");
    supp <= 1'b1;
    wait_cyc(4);
    chk(sw, 1'b1, "supplement");
    supp <= 1'b0;
    tend("termination");
    hold <= 1'b1;
    start_run(8'h0A, 1'b0);
    wait_phase(PH_TRI, 30);
    wait_phase(PH_IDLE, 60);
    chk(chg_on, 1'b0, "stopped");
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rd[STS_TRI_EXP], 1'b1, "expired flag");
    apb(1'b1, OFF_TIMER, 32'h0000_0006);
    start_run(8'h0A, 1'b0);
    wait_phase(PH_TRI, 30);
    wait_cyc(60);
    chk(ph, PH_TRI, "timer off");
    apb(1'b1, OFF_TIMER, 32'h0000_0007);
    temp_fault <= 1'b1;
    start_run(8'h0A, 1'b0);
    wait_cyc(30);
    chk({ph, chg_on}, {PH_IDLE, 1'b0}, "fault blocks");
    temp_fault <= 1'b0;
    wait_phase(PH_TRI, 30);
    tend("timers");
    for (i = 0; i < 6; i++)
    begin
      lfsr_r = lfsr_next(lfsr_r);
      lv = {1'b0, lfsr_r[6:0]};
      icl <= lfsr_r[0];
      ivl <= lfsr_r[1];
      apb(1'b1, OFF_CTRL, CTRL_RST | {29'h0, lfsr_r[7], 2'b00});
      start_run(lv, 1'b0);
      wait_phase(exp_start(lv), 30);
      wait_cyc(3);
      chk(smin_on, lv < 8'h3C && (!lfsr_r[7] || lv < 8'h14), "sysmin reg");
      chk(cur_red, lfsr_r[0] | lfsr_r[1], "reduced");
    end
    tend("random");
    print_verdict();
  end
endmodule // battery_charge_sequencer_bench
`default_nettype wire

// ==== testbench/bcs_batt_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module bcs_batt_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic charge_on,
  input wire logic hold,
  input wire logic skip_pre,
  input wire logic load,
  input wire logic [7:0] load_lvl,
  output logic vbat_below_target,
  output logic vbat_below_recharge,
  output logic vbat_below_deep,
  output logic vbat_below_fast_entry,
  output logic vbat_below_sysmin,
  output logic cv_loop_active,
  output logic ichg_below_term
);
  logic [7:0] lvl_r;
  logic [7:0] lvl_nxt;
  // Battery level climbs one step a cycle while charge current flows
  always_comb
  begin
    lvl_nxt = lvl_r;
    if (load)
      lvl_nxt = load_lvl;
    else if (charge_on && !hold && lvl_r < 8'hC8)
      lvl_nxt = lvl_r + 8'h01;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lvl_r <= 8'h00;
    else
      lvl_r <= lvl_nxt;
  end
  // Comparator levels; fast entry may equal the deep level
  assign vbat_below_deep = lvl_r < 8'h14;
  assign vbat_below_fast_entry = skip_pre ? vbat_below_deep : (lvl_r < 8'h28);
  assign vbat_below_sysmin = lvl_r < 8'h3C;
  assign vbat_below_recharge = lvl_r < 8'h96;
  assign vbat_below_target = lvl_r < 8'hC8;
  assign cv_loop_active = lvl_r >= 8'hB4;
  assign ichg_below_term = lvl_r >= 8'hC3;
endmodule // bcs_batt_model
`default_nettype wire
